// [design/smb_pkg.sv]
// package: constants, command codes and sizes of the spi master bridge
package smb_pkg;
  // clock rates and serial timing
  localparam int unsigned CLK_PERIOD_NS = 20;   // system clock period
  localparam int unsigned LNK_PERIOD_NS = 30;   // link clock period
  localparam int unsigned SCK_RATE_KBPS = 1000; // fixed serial bit rate
  localparam int unsigned SCK_HALF_NS   = 1000000 / (2 * SCK_RATE_KBPS);
  // half period is a least time, rounded up to link cycles
  localparam int unsigned SCK_HALF_CYC  = (SCK_HALF_NS + LNK_PERIOD_NS - 1) / LNK_PERIOD_NS;
  localparam int unsigned CS_GAP_NS     = 20;   // select hold after the last clock fall
  localparam int unsigned CS_GAP_RAW    = (CS_GAP_NS + LNK_PERIOD_NS - 1) / LNK_PERIOD_NS;
  localparam int unsigned CS_GAP_CYC    = (CS_GAP_RAW < 1) ? 1 : CS_GAP_RAW;
  // command payload layout
  localparam logic [5:0] POS_ADDR  = 6'h00;     // address byte
  localparam logic [5:0] POS_LEN   = 6'h01;     // length byte
  localparam logic [5:0] POS_DATA  = 6'h02;     // first data byte
  localparam logic [7:0] DATA_MAX  = 8'h36;     // data bytes per push
  localparam logic [7:0] RD_MAX    = 8'h38;     // bytes per read
  localparam logic [7:0] WR_MAX    = 8'h80;     // bytes per write frame
  localparam logic [5:0] RSP_HDR_N = 6'h02;     // header reply length
  localparam logic [5:0] RSP_BUF_N = 6'h38;     // buffer reply length
  localparam int unsigned RD_DEPTH = 56;        // read buffer entries
  localparam int unsigned WR_DEPTH = 128;       // queue entries
  // reset values
  localparam logic [7:0] HDR_ADDR_RST = 8'h00;  // read header address
  localparam logic [7:0] HDR_CNT_RST  = 8'h00;  // read header count
  // command codes
  typedef enum logic [2:0] {
    SMB_OP_PUSH,
    SMB_OP_QUEUE_APPEND_AND_RUN,
    SMB_OP_HDR_SET,
    SMB_OP_HDR_GET,
    SMB_OP_BUF_GET
  } smb_op_e;
endpackage

// [design/smb_spi_engine.sv]
// serial engine on the link clock: one framed transaction per start toggle, only a done toggle when booted over spi
`timescale 1ns/10ps
`default_nettype none
module smb_spi_engine (
  input  wire logic       lnk_clk_i,    // link clock
  input  wire logic       rst_b_i,      // async reset, active low
  input  wire logic       go_tgl_i,     // start event, toggle
  input  wire logic       rd_i,         // 1 read frame, 0 write
  input  wire logic [7:0] addr_i,       // address byte
  input  wire logic [7:0] wr_n_i,       // data bytes to write
  input  wire logic [5:0] rd_n_i,       // data bytes to read
  input  wire logic [7:0] tx_byte_i,    // queue byte at tx_idx_o
  output logic      [6:0] tx_idx_o,     // queue index wanted
  input  wire logic [5:0] rd_idx_i,     // buffer read index
  output logic      [7:0] rd_byte_o,    // buffer byte
  output logic            done_tgl_o,   // frame end, toggle
  input  wire logic       spi_booted_i, // strap: booted over spi
  input  wire logic       miso_i,       // serial data in
  output logic            sck_o,        // serial clock
  output logic            sck_oe_b_o,   // clock enable, low drives
  output logic            mosi_o,       // serial data out
  output logic            mosi_oe_b_o,  // data enable, low drives
  output logic            cs_b_o,       // chip select, active low
  output logic            cs_oe_b_o     // select enable, low drives
);
  import smb_pkg::*;
  typedef enum logic [1:0] {L_IDLE, L_LOW, L_HIGH, L_HOLD} smb_lst_e;
  localparam int HALF_A = SCK_HALF_CYC;        // high phase length
  localparam int HALF_REST = HALF_A - 8;       // high cycles left after the first 8
  localparam logic [4:0] HALF_END = 5'(SCK_HALF_CYC - 1);
  localparam logic [4:0] GAP_END = 5'(CS_GAP_CYC - 1);
  smb_lst_e   st_q;                  // frame state
  logic       rs1_q, rs2_q;          // reset release sync
  logic       g1_q, g2_q, g3_q;      // start toggle sync
  logic       m1_q, m2_q;            // data in sync
  logic       b1_q, b2_q;            // strap sync
  logic [1:0] cap_q;                 // strap capture delay
  logic       booted_q;              // port disabled
  logic [4:0] cnt_q;                 // phase timer
  logic [2:0] bit_q;                 // bit in byte
  logic [7:0] byte_q;                // byte in frame
  logic [7:0] sh_q, rx_q;            // out and in shifters
  logic       sck_q, cs_q, done_q;   // pin and event flops
  logic [7:0] rxm_q [RD_DEPTH];      // read buffer
  wire lrst_b = rs2_q;
  wire go_evt = g2_q ^ g3_q;
  wire half_end = cnt_q == HALF_END;
  wire rise = (st_q == L_LOW) && half_end;
  wire fall = (st_q == L_HIGH) && half_end;
  wire bit_end = bit_q == 3'h7;
  wire [7:0] tot = rd_i ? {2'b00, rd_n_i} : wr_n_i;
  wire last_byte = byte_q == tot;
  wire [7:0] next_sh = rd_i ? 8'h00 : tx_byte_i;
  // reset release and pin synchronisers
  always_ff @(posedge lnk_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {rs1_q, rs2_q} <= 2'b00;
    end else begin
      {rs1_q, rs2_q} <= {1'b1, rs1_q};
    end
  end
  always_ff @(posedge lnk_clk_i or negedge lrst_b) begin
    if (!lrst_b) begin
      {g1_q, g2_q, g3_q, m1_q, m2_q, b1_q, b2_q} <= 7'h00;
      cap_q <= 2'h0;
      booted_q <= 1'b1;
    end else begin
      {g1_q, g2_q, g3_q} <= {go_tgl_i, g1_q, g2_q};
      {m1_q, m2_q, b1_q, b2_q} <= {miso_i, m1_q, spi_booted_i, b1_q};
      if (cap_q != 2'h3) cap_q <= cap_q + 2'h1;
      if (cap_q == 2'h2) booted_q <= b2_q;
    end
  end
  // frame sequencer: select, clock phases, byte count
  always_ff @(posedge lnk_clk_i or negedge lrst_b) begin
    if (!lrst_b) begin
      st_q <= L_IDLE;
      {cnt_q, bit_q, byte_q} <= 16'h0000;
      {sck_q, cs_q, done_q} <= 3'b010;
    end else begin
      unique case (st_q)
        L_IDLE: if (go_evt && booted_q) begin
          done_q <= !done_q;
        end else if (go_evt) begin
          cs_q <= 1'b0;
          {cnt_q, bit_q, byte_q} <= 16'h0000;
          st_q <= L_LOW;
        end
        L_LOW: if (half_end) begin
          sck_q <= 1'b1;
          cnt_q <= 5'h00;
          st_q <= L_HIGH;
        end else cnt_q <= cnt_q + 5'h01;
        L_HIGH: if (half_end) begin
          sck_q <= 1'b0;
          cnt_q <= 5'h00;
          bit_q <= bit_q + 3'h1;
          if (bit_end && last_byte) st_q <= L_HOLD;
          else st_q <= L_LOW;
          if (bit_end) byte_q <= byte_q + 8'h01;
        end else cnt_q <= cnt_q + 5'h01;
        L_HOLD: if (cnt_q == GAP_END) begin
          cs_q <= 1'b1;
          done_q <= !done_q;
          st_q <= L_IDLE;
        end else cnt_q <= cnt_q + 5'h01;
      endcase
    end
  end
  // out shifter changes on the falling edge, msb first
  always_ff @(posedge lnk_clk_i or negedge lrst_b) begin
    if (!lrst_b) sh_q <= 8'h00;
    else if (st_q == L_IDLE && go_evt) sh_q <= addr_i;
    else if (fall) sh_q <= bit_end ? next_sh : {sh_q[6:0], 1'b0};
  end
  // in shifter samples on the rising edge
  always_ff @(posedge lnk_clk_i or negedge lrst_b) begin
    if (!lrst_b) rx_q <= 8'h00;
    else if (rise) rx_q <= {rx_q[6:0], m2_q};
  end
  // read buffer, unused entries keep stale data
  always_ff @(posedge lnk_clk_i) begin
    if (fall && bit_end && rd_i && byte_q != 8'h00) rxm_q[6'(byte_q - 8'h01)] <= rx_q;
  end
  assign tx_idx_o = byte_q[6:0];
  assign rd_byte_o = rxm_q[rd_idx_i];
  assign done_tgl_o = done_q;
  assign {sck_o, mosi_o, cs_b_o} = {sck_q, sh_q[7], cs_q};
  assign {sck_oe_b_o, mosi_oe_b_o, cs_oe_b_o} = {3{booted_q}};
  // checks on the serial side
  default clocking cb @(posedge lnk_clk_i); endclocking
  default disable iff (!lrst_b);
  sequence s_high;
    sck_q [*8] ##HALF_REST sck_q ##1 !sck_q;
  endsequence
  a_high_time: assert property ($rose(sck_q) |-> s_high)
    else $error("serial clock high phase wrong");
  a_sck_idle: assert property (cs_q |-> !sck_q)
    else $error("clock not idle low");
  a_mosi_hold: assert property (sck_q |-> $stable(mosi_o))
    else $error("data changed while clock high");
  a_read_quiet: assert property ((st_q != L_IDLE && rd_i && byte_q != 8'h00) |-> !mosi_o)
    else $error("data driven during read");
  a_cs_setup: assert property ($fell(cs_q) |-> !sck_q [*8])
    else $error("select setup too short");
  a_cs_hold: assert property ($rose(cs_q) |-> !$past(sck_q))
    else $error("select hold too short");
  a_frame_cs: assert property ((st_q == L_LOW || st_q == L_HIGH) |-> !cs_q)
    else $error("select released inside frame");
  a_boot_skip: assert property ((st_q == L_IDLE && go_evt && booted_q) |=>
    (cs_q && st_q == L_IDLE && done_q != $past(done_q)))
    else $error("disabled port framed");
endmodule
`default_nettype wire

// [design/smb_spi_bridge.sv]
// command bridge: queue, read header and read buffer before a mode-0 spi master
`timescale 1ns/10ps
`default_nettype none
module smb_spi_bridge (
  input  wire logic            clk_i,        // system clock
  input  wire logic            rst_b_i,      // async reset, low
  input  wire logic            cmd_valid_i,  // host byte valid
  output logic                 cmd_ready_o,  // host byte taken
  input  wire smb_pkg::smb_op_e cmd_op_i,    // host command
  input  wire logic      [7:0] cmd_byte_i,   // host payload byte
  input  wire logic            cmd_last_i,   // host last byte
  input  wire logic            boot_run_i,   // boot loader owns port
  input  wire logic            boot_valid_i, // boot byte valid
  output logic                 boot_ready_o, // boot byte taken
  input  wire smb_pkg::smb_op_e boot_op_i,   // boot command
  input  wire logic      [7:0] boot_byte_i,  // boot payload byte
  input  wire logic            boot_last_i,  // boot last byte
  output logic                 rsp_valid_o,  // reply byte valid
  input  wire logic            rsp_ready_i,  // reply byte taken
  output logic           [7:0] rsp_byte_o,   // reply byte
  output logic                 rsp_last_o,   // last reply byte
  output logic                 busy_o,       // frame running
  input  wire logic            lnk_clk_i,    // link clock
  input  wire logic            spi_booted_i, // strap, booted over spi
  input  wire logic            miso_i,       // serial data in
  output logic                 sck_o,        // serial clock
  output logic                 sck_oe_b_o,   // clock enable, low
  output logic                 mosi_o,       // serial data out
  output logic                 mosi_oe_b_o,  // data enable, low
  output logic                 cs_b_o,       // select, low
  output logic                 cs_oe_b_o     // select enable, low
);
  import smb_pkg::*;

  // command flow states
  typedef enum logic [1:0] {
    ST_IDLE,   // waiting for a command
    ST_TAKE,   // taking payload bytes
    ST_RUN,    // serial frame running
    ST_RESP    // streaming a reply
  } smb_st_e;

  smb_st_e    st_q, st_d;       // command state
  logic       src_q;            // 1: boot source
  smb_op_e    op_q;             // current command
  logic [5:0] idx_q, idx_d;     // payload position
  logic [7:0] len_q;            // valid data in push
  logic [7:0] q_addr_q;         // write frame address
  logic [7:0] q_len_q;          // bytes queued
  logic [7:0] h_addr_q;         // read header address
  logic [7:0] h_cnt_q;          // read header count
  logic       go_tgl_q;         // start toggle
  logic       rd_q;             // frame is a read
  logic       dn1_q;            // done sync stage 1
  logic       dn2_q;            // done sync stage 2
  logic       dn3_q;            // done edge history
  logic       rsp_hdr_q;        // reply is header
  logic [5:0] ridx_q, ridx_d;   // reply position
  logic [7:0] rsp_byte_q;       // reply byte flop
  logic [7:0] q_mem [WR_DEPTH]; // write queue

  logic [6:0] tx_idx;           // queue index from link
  logic [7:0] rd_byte;          // read buffer byte
  logic       done_tgl;         // frame end toggle
  smb_op_e    in_op;            // selected command
  smb_op_e    cur_op;           // command in progress

  // source select, fixed for a whole command
  wire src_sel = (st_q == ST_IDLE) ? boot_run_i : src_q;

  // input mux of host and boot streams
  wire       in_valid = src_sel ? boot_valid_i : cmd_valid_i;
  wire [7:0] in_byte  = src_sel ? boot_byte_i : cmd_byte_i;
  wire       in_last  = src_sel ? boot_last_i : cmd_last_i;
  assign in_op  = src_sel ? boot_op_i : cmd_op_i;
  assign cur_op = (st_q == ST_IDLE) ? in_op : op_q;

  // handshake: bytes are taken only between commands or in one
  wire take_rdy = (st_q == ST_IDLE) || (st_q == ST_TAKE);
  wire take     = in_valid && take_rdy;
  wire end_cmd  = take && in_last;
  assign cmd_ready_o  = take_rdy && !src_sel;
  assign boot_ready_o = take_rdy && src_sel;

  // command decode
  wire is_push = (cur_op == SMB_OP_PUSH) ||
                 (cur_op == SMB_OP_QUEUE_APPEND_AND_RUN);
  wire is_hset = cur_op == SMB_OP_HDR_SET;
  wire run_wr  = end_cmd && (cur_op == SMB_OP_QUEUE_APPEND_AND_RUN);
  wire run_rd  = end_cmd && (cur_op == SMB_OP_BUF_GET);
  wire hdr_get = end_cmd && (cur_op == SMB_OP_HDR_GET);

  // payload field decode
  wire [7:0] dpos = {2'b00, idx_q} - {2'b00, POS_DATA};
  wire in_data = (idx_q >= POS_DATA) && (dpos < len_q);
  wire room    = q_len_q < WR_MAX;
  wire append  = take && is_push && in_data && room;
  wire set_qa  = take && is_push && (idx_q == POS_ADDR) && (q_len_q == 8'h00);
  wire set_len = take && is_push && (idx_q == POS_LEN);
  wire set_ha  = take && is_hset && (idx_q == POS_ADDR);
  wire set_hc  = take && is_hset && (idx_q == POS_LEN);

  // length clamps
  wire [7:0] len_cl = (in_byte > DATA_MAX) ? DATA_MAX : in_byte;
  wire [7:0] cnt_cl = (in_byte > RD_MAX) ? RD_MAX : in_byte;

  // frame end seen from the link side
  wire done_evt = dn2_q ^ dn3_q;
  wire wr_done  = (st_q == ST_RUN) && done_evt && !rd_q;

  // reply stream decode
  wire [5:0] rsp_n    = rsp_hdr_q ? RSP_HDR_N : RSP_BUF_N;
  wire       rsp_fire = rsp_valid_o && rsp_ready_i;
  wire       rsp_enter = (st_d == ST_RESP) && (st_q != ST_RESP);
  wire       hdr_d    = rsp_enter ? hdr_get : rsp_hdr_q;
  wire [7:0] hdr_byte = (ridx_d == 6'h00) ? h_addr_q : h_cnt_q;
  wire [7:0] rsp_byte_d = hdr_d ? hdr_byte : rd_byte;

  // next command state
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE, ST_TAKE: begin
        if (run_wr || run_rd) begin
          st_d = ST_RUN;
        end else if (hdr_get) begin
          st_d = ST_RESP;
        end else if (end_cmd) begin
          st_d = ST_IDLE;
        end else if (take) begin
          st_d = ST_TAKE;
        end
      end
      ST_RUN: begin
        // reads go on to reply with the buffer
        if (done_evt) begin
          st_d = rd_q ? ST_RESP : ST_IDLE;
        end
      end
      ST_RESP: begin
        if (rsp_fire && rsp_last_o) begin
          st_d = ST_IDLE;
        end
      end
    endcase
  end

  // payload position, saturates past the last slot
  always_comb begin
    idx_d = idx_q;
    if (end_cmd) begin
      idx_d = 6'h00;
    end else if (take && idx_q != 6'h3f) begin
      idx_d = idx_q + 6'h01;
    end
  end

  // reply position
  always_comb begin
    ridx_d = ridx_q;
    if (rsp_enter) begin
      ridx_d = 6'h00;
    end else if (rsp_fire) begin
      ridx_d = ridx_q + 6'h01;
    end
  end

  // state, source and command flops
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q  <= ST_IDLE;
      src_q <= 1'b0;
      op_q  <= SMB_OP_PUSH;
      idx_q <= 6'h00;
    end else begin
      st_q  <= st_d;
      idx_q <= idx_d;
      if (st_q == ST_IDLE) begin
        src_q <= boot_run_i;
        op_q  <= in_op;
      end
    end
  end

  // push fields and queue length
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      len_q    <= 8'h00;
      q_addr_q <= 8'h00;
      q_len_q  <= 8'h00;
    end else begin
      if (set_len) len_q <= len_cl;
      if (set_qa) q_addr_q <= in_byte;
      if (wr_done) begin
        q_len_q <= 8'h00;
      end else if (append) begin
        q_len_q <= q_len_q + 8'h01;
      end
    end
  end

  // queue storage, written only with valid data
  always_ff @(posedge clk_i) begin
    if (append) q_mem[q_len_q[6:0]] <= in_byte;
  end

  // read header registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      h_addr_q <= HDR_ADDR_RST;
      h_cnt_q  <= HDR_CNT_RST;
    end else begin
      if (set_ha) h_addr_q <= in_byte;
      if (set_hc) h_cnt_q <= cnt_cl;
    end
  end

  // start toggle and frame kind
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      go_tgl_q <= 1'b0;
      rd_q     <= 1'b0;
    end else if (run_wr || run_rd) begin
      go_tgl_q <= !go_tgl_q;
      rd_q     <= run_rd;
    end
  end

  // done toggle crossing into the system clock
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {dn1_q, dn2_q, dn3_q} <= 3'b000;
    end else begin
      {dn1_q, dn2_q, dn3_q} <= {done_tgl, dn1_q, dn2_q};
    end
  end

  // reply flops
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rsp_hdr_q  <= 1'b0;
      ridx_q     <= 6'h00;
      rsp_byte_q <= 8'h00;
    end else begin
      rsp_hdr_q  <= hdr_d;
      ridx_q     <= ridx_d;
      rsp_byte_q <= rsp_byte_d;
    end
  end

  // serial engine on the link clock; frame inputs stay still while busy
  smb_spi_engine u_engine (
    .lnk_clk_i    (lnk_clk_i),
    .rst_b_i      (rst_b_i),
    .go_tgl_i     (go_tgl_q),
    .rd_i         (rd_q),
    .addr_i       (rd_q ? h_addr_q : q_addr_q),
    .wr_n_i       (q_len_q),
    .rd_n_i       (h_cnt_q[5:0]),
    .tx_byte_i    (q_mem[tx_idx]),
    .tx_idx_o     (tx_idx),
    .rd_idx_i     (ridx_d),
    .rd_byte_o    (rd_byte),
    .done_tgl_o   (done_tgl),
    .spi_booted_i (spi_booted_i),
    .miso_i       (miso_i),
    .sck_o        (sck_o),
    .sck_oe_b_o   (sck_oe_b_o),
    .mosi_o       (mosi_o),
    .mosi_oe_b_o  (mosi_oe_b_o),
    .cs_b_o       (cs_b_o),
    .cs_oe_b_o    (cs_oe_b_o)
  );

  // outputs
  assign rsp_valid_o = st_q == ST_RESP;
  assign rsp_byte_o  = rsp_byte_q;
  assign rsp_last_o  = rsp_valid_o && (ridx_q == rsp_n - 6'h01);
  assign busy_o      = st_q == ST_RUN;

  // checks on the command side
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_queue_bound: assert property (
    q_len_q <= WR_MAX)
    else $error("queue longer than a write frame");

  a_read_limit: assert property (
    h_cnt_q <= RD_MAX)
    else $error("read count above limit");

  a_push_cap: assert property (
    set_len |=> (len_q <= DATA_MAX))
    else $error("push length not clamped");

  a_push_no_go: assert property (
    (end_cmd && cur_op == SMB_OP_PUSH) |=> ($stable(go_tgl_q) && st_q == ST_IDLE))
    else $error("plain push started a frame");

  a_run_go: assert property (
    run_wr |=> (st_q == ST_RUN && go_tgl_q != $past(go_tgl_q)))
    else $error("append and run did not start");

  a_queue_empty: assert property (
    wr_done |=> (q_len_q == 8'h00 && st_q == ST_IDLE))
    else $error("queue kept after execution");

  a_hdr_reply: assert property (
    (rsp_fire && rsp_hdr_q && ridx_q == 6'h00) |-> (rsp_byte_o == h_addr_q))
    else $error("header reply lost the address");

  a_buf_len: assert property (
    (rsp_fire && rsp_last_o && !rsp_hdr_q) |-> (ridx_q == 6'(RD_DEPTH - 1)))
    else $error("buffer reply not 56 bytes");

  a_boot_src: assert property (
    (st_q == ST_IDLE && boot_run_i) |-> (!cmd_ready_o))
    else $error("host taken while boot owns port");
endmodule
`default_nettype wire

// [tb/smb_spi_slave.sv]
// spi peripheral model: mode 0, msb first, reply bytes count up from a base
`timescale 1ns/10ps
`default_nettype none
module smb_spi_slave #(parameter logic [7:0] RD_BASE = 8'ha0) (
  input  wire logic       sck_i,  // serial clock
  input  wire logic       cs_b_i, // select, low
  input  wire logic       mosi_i, // data in
  output logic            miso_o, // data out
  output logic      [7:0] rx_o,   // byte taken
  output logic            stb_o   // byte strobe
);
  logic [7:0] sh, tx; // shift in, shift out
  int         nb, ny; // bit and byte counts
  initial begin
    miso_o = 1'b0;
    stb_o = 1'b0;
    nb = 0;
  end
  // new frame at select fall
  always @(negedge cs_b_i) begin
    nb = 0;
    ny = 0;
    tx = RD_BASE - 8'h01;
    miso_o = tx[7];
  end
  // released line has no pull: show the inverse
  always @(posedge cs_b_i) miso_o = ~miso_o;
  // sample on the rising clock, receive in every frame, reads included
  always @(posedge sck_i) begin
    stb_o = 1'b0;
    sh = {sh[6:0], mosi_i};
    nb = nb + 1;
    if (nb == 8) begin
      nb = 0;
      rx_o = sh;
      stb_o = 1'b1;
    end
  end
  // change on the falling clock, data after the address byte
  always @(negedge sck_i) begin
    if (nb == 0) begin
      ny = ny + 1;
      tx = RD_BASE + 8'(ny - 1);
    end else begin
      tx = tx << 1;
    end
    miso_o = tx[7];
  end
endmodule
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the spi command bridge
`timescale 1ns/10ps
`default_nettype none
module tb;
  import smb_pkg::*;
  localparam logic [7:0] RBASE = 8'ha0; // first byte the model returns
  logic clk_i, rst_b_i, lnk_clk_i, spi_booted_i, miso_i, boot_run_i, rsp_ready_i;
  logic cmd_valid_i, cmd_last_i, cmd_ready_o, boot_valid_i, boot_last_i, boot_ready_o;
  logic rsp_valid_o, rsp_last_o, busy_o, sck_o, sck_oe_b_o, mosi_o, mosi_oe_b_o;
  logic cs_b_o, cs_oe_b_o, rx_stb;
  logic [7:0] cmd_byte_i, boot_byte_i, rsp_byte_o, rx_byte;
  smb_op_e    cmd_op_i, boot_op_i;
  logic [9:0] exp_rsp [$]; // care, last, byte
  logic [7:0] exp_spi [$]; // bytes the peripheral should see
  logic [9:0] e;
  int         num_errors, tests_run, seed, i;
  smb_spi_bridge DUT (.*);
  smb_spi_slave #(.RD_BASE(RBASE)) u_per (.sck_i(sck_o), .cs_b_i(cs_b_o),
    .mosi_i(mosi_o), .miso_o(miso_i), .rx_o(rx_byte), .stb_o(rx_stb));
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic close_out;
    if (num_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // offer each byte until the selected port takes it
  task automatic send(input logic s, input smb_op_e op, input logic [7:0] pl [$]);
    for (int k = 0; k < pl.size(); k++) begin
      cmd_valid_i <= !s;
      boot_valid_i <= s;
      cmd_op_i <= op;
      boot_op_i <= op;
      cmd_byte_i <= pl[k];
      boot_byte_i <= pl[k];
      cmd_last_i <= (k == pl.size() - 1);
      boot_last_i <= (k == pl.size() - 1);
      @(negedge clk_i);
      while ((s ? boot_ready_o : cmd_ready_o) !== 1'b1) @(negedge clk_i);
      @(posedge clk_i);
    end
    cmd_valid_i <= 1'b0;
    boot_valid_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // padded push: random data, only n bytes expected on the wire
  task automatic push(input logic s, input smb_op_e op, input logic [7:0] a, input int n);
    logic [7:0] pl [$];
    logic [7:0] d;
    pl = {a, n[7:0]};
    for (int k = 0; k < 54; k++) begin
      d = 8'($random(seed));
      if (k < n) exp_spi.push_back(d);
      pl.push_back(d);
    end
    send(s, op, pl);
  endtask
  // bounded wait for frame end and all replies
  task automatic settle(input int lim);
    i = 0;
    repeat (10) @(negedge clk_i);
    while ((busy_o !== 1'b0 || exp_rsp.size() > 0) && i < lim) begin
      @(negedge clk_i);
      i++;
    end
    chk(i < lim, "no completion");
    chk(exp_spi.size() == 0, "serial bytes missing");
    @(posedge clk_i);
  endtask
  // reply watcher with a stalling consumer
  always @(posedge clk_i) rsp_ready_i <= 1'($random(seed));
  always @(negedge clk_i) begin
    if (rsp_valid_o === 1'b1 && rsp_ready_i === 1'b1) begin
      chk(exp_rsp.size() > 0, "extra reply");
      e = exp_rsp.pop_front();
      chk((!e[9] || rsp_byte_o === e[7:0]) && rsp_last_o === e[8], "reply");
    end
  end
  // serial watcher
  always @(posedge rx_stb) begin
    chk(exp_spi.size() > 0, "extra serial byte");
    chk(rx_byte === exp_spi.pop_front(), "serial byte");
  end
  always @(cs_b_o) if (rst_b_i === 1'b1) chk(sck_o === 1'b0, "clock not idle");
  always @(posedge sck_o) chk(cs_b_o === 1'b0, "clock outside select");
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    lnk_clk_i = 1'b0;
    #7;
    forever #15 lnk_clk_i = ~lnk_clk_i;
  end
  initial begin
    #1500000;
    num_errors++;
    close_out();
  end
  initial begin
    seed = 12; num_errors = 0; tests_run = 0; rst_b_i = 0; spi_booted_i = 0; boot_run_i = 0;
    cmd_valid_i = 0; cmd_last_i = 0; cmd_byte_i = 8'h00; cmd_op_i = SMB_OP_PUSH;
    boot_valid_i = 0; boot_last_i = 0; boot_byte_i = 8'h00; boot_op_i = SMB_OP_PUSH;
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk({sck_oe_b_o, mosi_oe_b_o, cs_oe_b_o} === 3'b000, "port not driven");
    exp_rsp = {10'h205, 10'h303};
    send(1'b0, SMB_OP_HDR_SET, {8'h05, 8'h03});
    send(1'b0, SMB_OP_HDR_GET, {8'h00});
    settle(100);
    exp_spi = {8'h64};
    push(1'b0, SMB_OP_PUSH, 8'h64, 54);
    repeat (200) @(posedge clk_i);
    chk(busy_o === 1'b0 && cs_b_o === 1'b1, "push alone started a frame");
    push(1'b0, SMB_OP_QUEUE_APPEND_AND_RUN, 8'h99, 1);
    settle(40000);
    boot_run_i <= 1'b1;
    @(posedge clk_i);
    exp_spi = {8'h22};
    push(1'b1, SMB_OP_QUEUE_APPEND_AND_RUN, 8'h22, 3);
    settle(5000);
    boot_run_i <= 1'b0;
    exp_spi = {8'h05, 8'h00, 8'h00, 8'h00};
    for (i = 0; i < 56; i++) exp_rsp.push_back({i < 3, i == 55, RBASE + i[7:0]});
    send(1'b0, SMB_OP_BUF_GET, {8'h00});
    settle(10000);
    // second reset with the spi boot strap set: port stays undriven, frames skipped
    rst_b_i <= 1'b0;
    spi_booted_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    chk({sck_oe_b_o, mosi_oe_b_o, cs_oe_b_o} === 3'b111, "port driven after spi boot");
    exp_rsp = {10'h211, 10'h338};
    send(1'b0, SMB_OP_HDR_SET, {8'h11, 8'hff});
    send(1'b0, SMB_OP_HDR_GET, {8'h00});
    for (i = 0; i < 56; i++) exp_rsp.push_back({1'b0, i == 55, 8'h00});
    send(1'b0, SMB_OP_BUF_GET, {8'h00});
    settle(1000);
    chk(cs_b_o === 1'b1 && cs_oe_b_o === 1'b1, "spi booted port framed");
    close_out();
  end
endmodule
`default_nettype wire
